// ==== hdl/dual_vga_gain_control_port.sv ====
// gain control front end for a dual channel programmable gain amplifier
//
// Contract
// - The block works only while chip_on is high and holds everything idle while it is low.
// - Each channel has its own path enable and only takes a gain word while that enable is high.
// - serial_select low picks parallel gain entry and high picks serial entry.
// - In parallel mode the six gain pins weigh 0.25, 0.5, 1, 2, 4 and 8 dB from lowest to highest.
// - In serial mode gain_w0 is chip select, gain_w1 serial data and gain_w2 serial clock.
// - In serial mode gain_w3 to gain_w5 have no effect.
`timescale 1ns/1ps
`include "gain_port_cfg.svh"
module dual_vga_gain_control_port (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic chip_on_in,
    input wire logic chan_a_path_on_in,
    input wire logic chan_b_path_on_in,
    input wire logic serial_select_in,
    input wire logic gain_w0_in,
    input wire logic gain_w1_in,
    input wire logic gain_w2_in,
    input wire logic gain_w3_in,
    input wire logic gain_w4_in,
    input wire logic gain_w5_in,
    output gain_port_pkg::gain_word_t chan_a_gain_out,
    output gain_port_pkg::gain_word_t chan_b_gain_out,
    output logic active_out,
    output logic serial_busy_out
);
    import gain_port_pkg::*;

    // ------------------------------------------------------------
    // pin roles
    // ------------------------------------------------------------
    logic cs_n;
    logic sdata;
    logic sclk;
    gain_word_t par_word;
    assign cs_n = gain_w0_in; // select is active low
    assign sdata = gain_w1_in;
    assign sclk = gain_w2_in;
    // binary weighted parallel word, gain_w0 = 0.25 dB
    assign par_word = {gain_w5_in, gain_w4_in, gain_w3_in, gain_w2_in, gain_w1_in, gain_w0_in};

    // ------------------------------------------------------------
    // serial clock edge and select tracking
    // ------------------------------------------------------------
    logic sclk_q;
    logic cs_n_q;
    // select idles high and serial clock low, so reset leaves no false edge
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            sclk_q <= sclk;
            cs_n_q <= cs_n;
        end
    end
    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;
    // one cycle strobes for the serial clock rise and both select edges
    assign sclk_rise = sclk & ~sclk_q;
    assign cs_fall = ~cs_n & cs_n_q;
    assign cs_rise = cs_n & ~cs_n_q;

    // ------------------------------------------------------------
    // serial frame state machine
    // ------------------------------------------------------------
    ser_state_t state_q;
    ser_state_t state_d;
    logic ser_mode;
    // mode choice from the select pin, gated by the chip enable
    assign ser_mode = serial_select_in & chip_on_in;
    // next state; a select drop in the apply cycle is missed, so select must stay high two cycles
    always_comb begin
        state_d = state_q;
        case (state_q)
            SER_IDLE: begin
                if (ser_mode && cs_fall) begin
                    state_d = SER_SHIFT;
                end
            end
            SER_SHIFT: begin
                if (!ser_mode) begin
                    state_d = SER_IDLE;
                end else if (cs_rise) begin
                    state_d = SER_APPLY;
                end
            end
            SER_APPLY: state_d = SER_IDLE;
            default: state_d = SER_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            state_q <= SER_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // shift register and bit count
    // ------------------------------------------------------------
    gain_word_t shift_q;
    logic [`SHIFT_CNT_W-1:0] cnt_q;
    // the count stops at six, so an overlong frame keeps its last six bits
    // msb first shift on rising serial clock while selected
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            shift_q <= `GAIN_RESET_WORD;
            cnt_q <= '0;
        end else if (state_q == SER_IDLE) begin
            cnt_q <= '0;
        end else if (state_q == SER_SHIFT && !cs_n && sclk_rise) begin
            shift_q <= {shift_q[`GAIN_WORD_W-2:0], sdata};
            if (cnt_q != `SHIFT_CNT_FULL) begin
                cnt_q <= cnt_q + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // word selection and channel loads
    // ------------------------------------------------------------
    logic ser_apply;
    gain_word_t next_word;
    logic load_a;
    logic load_b;
    // apply only a frame of at least six bits on select release
    assign ser_apply = (state_q == SER_APPLY) && (cnt_q == `SHIFT_CNT_FULL);
    // upper pins only ever feed the parallel word
    assign next_word = ser_mode ? shift_q : par_word;
    // nothing loads while the chip is off
    // per channel path enables gate the loads
    assign load_a = chip_on_in & chan_a_path_on_in & (ser_mode ? ser_apply : 1'b1);
    assign load_b = chip_on_in & chan_b_path_on_in & (ser_mode ? ser_apply : 1'b1);

    // both channels share one word; the path enables decide who takes it
    gain_hold u_hold_a (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .load_in(load_a),
        .word_in(next_word),
        .word_out(chan_a_gain_out)
    );
    gain_hold u_hold_b (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .load_in(load_b),
        .word_in(next_word),
        .word_out(chan_b_gain_out)
    );

    // status outputs
    // busy follows the next state so it rises on the edge that opens a frame
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            active_out <= 1'b0;
            serial_busy_out <= 1'b0;
        end else begin
            active_out <= chip_on_in;
            serial_busy_out <= (state_d == SER_SHIFT);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_off_holds_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !$past(chip_on_in) |-> $stable(chan_a_gain_out)) else $error("gain changed while chip off");
    a_path_b_hold: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !$past(chan_b_path_on_in) |-> $stable(chan_b_gain_out)) else $error("chan b changed while path off");
    a_par_follow: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (chip_on_in && chan_a_path_on_in && !serial_select_in) |=> chan_a_gain_out == $past(par_word))
        else $error("parallel word not taken");
    a_par_no_shift: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !serial_select_in |=> state_q == SER_IDLE || state_q == SER_APPLY) else $error("shift in parallel mode");
    a_ser_upper_ign: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        ($past(ser_mode) && !$past(ser_apply)) |-> $stable(chan_a_gain_out)) else $error("serial gain moved early");
    a_ser_apply_b: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (ser_apply && ser_mode && chan_b_path_on_in) |=> chan_b_gain_out == $past(shift_q))
        else $error("serial word not applied");
    a_ser_shift_pin: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SER_SHIFT && !cs_n && sclk_rise) |=> shift_q[0] == $past(sdata)) else $error("serial bit lost");
    a_apply_once: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        state_q == SER_APPLY |=> state_q == SER_IDLE ##1 state_q != SER_APPLY) else $error("apply state repeated");

    // ------------------------------------------------------------
    // checks on both channels, the frame edges and the status
    // ------------------------------------------------------------
    // chip off freezes channel b too
    a_off_holds_b: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !$past(chip_on_in) |-> $stable(chan_b_gain_out)) else $error("chan b changed while chip off");
    // path a off freezes channel a
    a_path_a_hold: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !$past(chan_a_path_on_in) |-> $stable(chan_a_gain_out)) else $error("chan a changed while path off");
    // parallel word reaches channel b
    a_par_follow_b: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (chip_on_in && chan_b_path_on_in && !serial_select_in) |=> chan_b_gain_out == $past(par_word))
        else $error("parallel word not taken on b");
    // chip off closes any open frame
    a_off_no_frame: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !chip_on_in |=> state_q == SER_IDLE) else $error("frame open while chip off");
    // a complete frame reaches channel a
    a_ser_apply_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (ser_apply && ser_mode && chan_a_path_on_in) |=> chan_a_gain_out == $past(shift_q))
        else $error("serial word not applied on a");
    // a short frame changes no gain
    a_short_drop: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SER_APPLY && cnt_q != `SHIFT_CNT_FULL && ser_mode)
        |=> $stable(chan_a_gain_out) && $stable(chan_b_gain_out)) else $error("short frame applied");
    // active follows the chip enable one cycle late
    a_active_follow: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        chip_on_in |=> active_out) else $error("active missing while chip on");
    // active drops one cycle after the chip enable
    a_active_low: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !chip_on_in |=> !active_out) else $error("active set while chip off");
endmodule : dual_vga_gain_control_port

// ==== hdl/gain_hold.sv ====
// per channel gain word holding register
`timescale 1ns/1ps
`include "gain_port_cfg.svh"
module gain_hold (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic load_in,
    input wire gain_port_pkg::gain_word_t word_in,
    output gain_port_pkg::gain_word_t word_out
);
    import gain_port_pkg::*;
    // holding register, cleared by reset
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            word_out <= `GAIN_RESET_WORD;
        end else if (load_in) begin
            word_out <= word_in;
        end
    end
endmodule : gain_hold

// ==== inc/gain_port_cfg.svh ====
// constants for the dual channel gain control port
`ifndef GAIN_PORT_CFG_SVH
`define GAIN_PORT_CFG_SVH
`define GAIN_WORD_W 6
`define GAIN_RESET_WORD 6'h00
`define SHIFT_CNT_W 3
`define SHIFT_CNT_FULL 3'h6
`define GAIN_STEP_MDB 250
`endif

// ==== inc/gain_port_pkg.sv ====
// types for the dual channel gain control port
`include "gain_port_cfg.svh"
package gain_port_pkg;
    typedef logic [`GAIN_WORD_W-1:0] gain_word_t;
    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_SHIFT = 2'b01,
        SER_APPLY = 2'b11
    } ser_state_t;
endpackage : gain_port_pkg

// ==== testbench/dual_vga_gain_control_port_tb.sv ====
// self-checking bench for the gain control port
`timescale 1ns/1ps
module dual_vga_gain_control_port_tb;
    import gain_port_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic chip = 1'b0;
    logic on_a = 1'b0;
    logic on_b = 1'b0;
    logic sel = 1'b0;
    logic [5:0] pins;
    gain_word_t g_a;
    gain_word_t g_b;
    logic act;
    logic busy;
    int n_fail = 0;
    int total_checks = 0;
    // rows: chip, path a, path b, pin word, expected a, expected b
    logic [20:0] rows [5] = '{{3'h7, 6'h3F, 6'h3F, 6'h3F}, {3'h6, 6'h01, 6'h01, 6'h3F},
        {3'h5, 6'h20, 6'h01, 6'h20}, {3'h3, 6'h15, 6'h01, 6'h20}, {3'h7, 6'h2A, 6'h2A, 6'h2A}};
    gain_host host_u (.sys_clk_in(clk), .pins_out(pins));
    dual_vga_gain_control_port dut_u (.sys_clk_in(clk), .reset_in(rst), .chip_on_in(chip),
        .chan_a_path_on_in(on_a), .chan_b_path_on_in(on_b), .serial_select_in(sel),
        .gain_w0_in(pins[0]), .gain_w1_in(pins[1]), .gain_w2_in(pins[2]), .gain_w3_in(pins[3]),
        .gain_w4_in(pins[4]), .gain_w5_in(pins[5]), .chan_a_gain_out(g_a), .chan_b_gain_out(g_b),
        .active_out(act), .serial_busy_out(busy));
    task automatic chk(input logic [5:0] got, input logic [5:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    // 200 MHz clock
    initial forever #2.5 clk = ~clk;
    // watchdog, tests need well under 1000 cycles
    initial begin
        #20000;
        n_fail++;
        summarize();
    end
    initial begin
        int i;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 5; i++) begin
            @(posedge clk);
            {chip, on_a, on_b} <= rows[i][20:18];
            host_u.par(rows[i][17:12]);
            repeat (2) @(posedge clk);
            #1;
            chk(g_a, rows[i][11:6]);
            chk(g_b, rows[i][5:0]);
            chk({5'h00, act}, {5'h00, rows[i][20]});
            $display("row %0d done", i);
        end
        @(posedge clk);
        {chip, on_a, on_b, sel} <= 4'hD;
        fork
            host_u.frame(6'h2D, 6);
            begin
                repeat (8) @(posedge clk);
                #1 chk({5'h00, busy}, 6'h01);
            end
        join
        repeat (4) @(posedge clk);
        #1;
        chk(g_a, 6'h2D);
        chk(g_b, 6'h2A);
        chk({5'h00, busy}, 6'h00);
        $display("serial frame done");
        host_u.frame(6'h13, 5);
        repeat (4) @(posedge clk);
        #1;
        chk(g_a, 6'h2D);
        $display("short frame done");
        // serial word to channel b only
        @(posedge clk);
        {on_a, on_b} <= 2'h1;
        host_u.frame(6'h13, 6);
        repeat (4) @(posedge clk);
        #1;
        chk(g_b, 6'h13);
        chk(g_a, 6'h2D);
        $display("channel b frame done");
        @(posedge clk);
        chip <= 1'b0;
        host_u.frame(6'h3C, 6);
        repeat (4) @(posedge clk);
        #1;
        chk(g_a, 6'h2D);
        chk(g_b, 6'h13);
        chk({5'h00, act}, 6'h00);
        $display("chip off frame done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(g_a, 6'h00);
        chk({act, busy, g_b[3:0]}, 6'h00);
        $display("reset done");
        summarize();
    end
endmodule : dual_vga_gain_control_port_tb

// ==== testbench/gain_host.sv ====
// host model that drives the shared gain and serial pins
`timescale 1ns/1ps
module gain_host (
    input wire logic sys_clk_in,
    output logic [5:0] pins_out
);
    initial pins_out = 6'h00;
    task automatic par(input logic [5:0] w);
        pins_out <= w;
    endtask : par
    // select low, msb first, junk on upper pins
    task automatic frame(input logic [5:0] w, input int n);
        int i;
        @(posedge sys_clk_in) pins_out <= 6'h01;
        @(posedge sys_clk_in) pins_out <= 6'h28;
        for (i = n - 1; i >= 0; i--) begin
            repeat (2) @(posedge sys_clk_in);
            pins_out <= {3'h5, 1'b0, w[i], 1'b0};
            repeat (2) @(posedge sys_clk_in);
            pins_out <= {3'h2, 1'b1, w[i], 1'b0};
        end
        repeat (2) @(posedge sys_clk_in);
        pins_out <= 6'h01;
    endtask : frame
endmodule : gain_host
